// ---- logic/dsadc_top.sv ----
// Delta-sigma converter control with AXI4-Lite register access
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dsadc_top (
  input wire logic mclk, // 10 MHz system clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:0] modIn, // Modulator codes, 2 bits per channel
  input wire logic tickXtal, // Toggles per modulator sample, crystal
  input wire logic tickOsc, // Toggles per modulator sample, oscillator
  output logic [3:0] chanPowerOn, // Analogue power-on per channel
  output logic [11:0] pgaGain, // Gain code per channel, 3 bits each
  output logic convClkSel, // 1 selects internal oscillator
  output logic convDoneIrq // One pulse per result set
);
  localparam int N = dsadc_pkg::NUM_CH;

  // Clamp a gain code to what the channel supports
  function automatic logic [2:0] clampGain(input logic [2:0] code, input bit cur);
    logic [2:0] lim;
    lim = cur ? dsadc_pkg::GAIN_MAX_CUR : dsadc_pkg::GAIN_MAX_VOL;
    clampGain = (code > lim) ? lim : code;
  endfunction : clampGain

  // Merge write data under byte enables
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = dat[8*b +: 8];
      end
    end
    mergeStrb = m;
  endfunction : mergeStrb

  // Configuration registers
  logic [dsadc_pkg::MODE_W-1:0] mode_r, mode_nxt; // conv_mode_reg
  logic [7:0] gainLo_r, gainLo_nxt; // gain_ctrl_reg_lo
  logic [7:0] gainHi_r, gainHi_nxt; // gain_ctrl_reg_hi
  logic [7:0] phase_r, phase_nxt; // Phase delay fields
  // Bus response state
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wrGo, rdGo; // Bus transfers taken this cycle
  logic [31:0] wrMerged; // Write data over old value
  // Pin synchronisers
  logic [7:0] modSyncA_r, modSyncB_r; // Modulator codes
  logic [1:0] tickSyncA_r, tickSyncB_r, tickSyncC_r; // Tick toggles
  // Conversion state
  logic [10:0] frameCnt_r, frameCnt_nxt; // Ticks within a sample
  logic [7:0] convCnt_r [N]; // Conversions since power-on
  logic [7:0] convCnt_nxt [N];
  logic irq_r, irq_nxt;
  logic [3:0] pon, cen, running;
  logic tick, dump;
  logic [10:0] framePeriod;
  logic [23:0] res [N]; // Channel results

  assign pon = mode_r[dsadc_pkg::F_PON +: 4];
  assign cen = mode_r[dsadc_pkg::F_CEN +: 4];
  assign running = pon & cen;

  // Bus handshakes; both write channels taken together
  always_comb begin
    wrGo = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    rdGo = ce && s_axi_arvalid && !rvalid_r;
  end
  assign s_axi_awready = wrGo;
  assign s_axi_wready = wrGo;
  assign s_axi_arready = rdGo;

  // Register writes and write response
  always_comb begin
    mode_nxt = mode_r;
    gainLo_nxt = gainLo_r;
    gainHi_nxt = gainHi_r;
    phase_nxt = phase_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wrMerged = 32'h0;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0; // Response accepted
    end
    if (wrGo) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = dsadc_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        dsadc_pkg::OFF_MODE: begin
          wrMerged = mergeStrb(32'(mode_r), s_axi_wdata, s_axi_wstrb);
          mode_nxt = wrMerged[dsadc_pkg::MODE_W-1:0];
          // Rate bit held while any channel is powered
          if (pon != 4'h0) begin
            mode_nxt[dsadc_pkg::F_RATE] = mode_r[dsadc_pkg::F_RATE];
          end
        end
        dsadc_pkg::OFF_GAIN_LO: begin
          wrMerged = mergeStrb(32'(gainLo_r), s_axi_wdata, s_axi_wstrb);
          gainLo_nxt = wrMerged[7:0];
        end
        dsadc_pkg::OFF_GAIN_HI: begin
          wrMerged = mergeStrb(32'(gainHi_r), s_axi_wdata, s_axi_wstrb);
          gainHi_nxt = wrMerged[7:0];
        end
        dsadc_pkg::OFF_PHASE: begin
          wrMerged = mergeStrb(32'(phase_r), s_axi_wdata, s_axi_wstrb);
          phase_nxt = wrMerged[7:0];
        end
        default: begin
          bresp_nxt = dsadc_pkg::RESP_SLVERR; // Unmapped or read-only
        end
      endcase
    end
  end

  // Read data and read response
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rdGo) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = dsadc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dsadc_pkg::OFF_MODE: rdata_nxt = 32'(mode_r);
        dsadc_pkg::OFF_GAIN_LO: rdata_nxt = 32'(gainLo_r);
        dsadc_pkg::OFF_GAIN_HI: rdata_nxt = 32'(gainHi_r);
        dsadc_pkg::OFF_PHASE: rdata_nxt = 32'(phase_r);
        dsadc_pkg::OFF_STAT: begin
          rdata_nxt = {convCnt_r[3], convCnt_r[2], convCnt_r[1], convCnt_r[0]};
        end
        dsadc_pkg::OFF_RES0: rdata_nxt = 32'(res[0]);
        dsadc_pkg::OFF_RES0 + 8'h04: rdata_nxt = 32'(res[1]);
        dsadc_pkg::OFF_RES0 + 8'h08: rdata_nxt = 32'(res[2]);
        dsadc_pkg::OFF_RES0 + 8'h0c: rdata_nxt = 32'(res[3]);
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = dsadc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Register bank and bus response flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r <= dsadc_pkg::MODE_RST;
      gainLo_r <= dsadc_pkg::GAIN_RST;
      gainHi_r <= dsadc_pkg::GAIN_RST;
      phase_r <= dsadc_pkg::PHASE_RST;
      bvalid_r <= 1'b0;
      bresp_r <= dsadc_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= dsadc_pkg::RESP_OKAY;
      rdata_r <= 32'h0;
    end else if (ce) begin
      mode_r <= mode_nxt;
      gainLo_r <= gainLo_nxt;
      gainHi_r <= gainHi_nxt;
      phase_r <= phase_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Two-flop synchronisers; third tick stage only for edge finding
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      modSyncA_r <= 8'h00;
      modSyncB_r <= 8'h00;
      tickSyncA_r <= 2'h0;
      tickSyncB_r <= 2'h0;
      tickSyncC_r <= 2'h0;
    end else if (ce) begin
      modSyncA_r <= modIn;
      modSyncB_r <= modSyncA_r;
      tickSyncA_r <= {tickOsc, tickXtal};
      tickSyncB_r <= tickSyncA_r;
      tickSyncC_r <= tickSyncB_r;
    end
  end

  // Tick from the selected converter clock source
  always_comb begin
    convClkSel = mode_r[dsadc_pkg::F_CLK];
    tick = convClkSel ? (tickSyncB_r[1] ^ tickSyncC_r[1])
                      : (tickSyncB_r[0] ^ tickSyncC_r[0]);
    framePeriod = mode_r[dsadc_pkg::F_RATE] ? 11'(dsadc_pkg::DEC_SLOW - 1)
                                            : 11'(dsadc_pkg::DEC_FAST - 1);
    dump = tick && (frameCnt_r >= framePeriod);
  end

  // Frame counter, conversion counts and done pulse
  always_comb begin
    frameCnt_nxt = frameCnt_r;
    if (dump) begin
      frameCnt_nxt = 11'h0;
    end else if (tick) begin
      frameCnt_nxt = frameCnt_r + 11'h1;
    end
    for (int i = 0; i < N; i++) begin
      convCnt_nxt[i] = convCnt_r[i];
      if (!pon[i]) begin
        convCnt_nxt[i] = 8'h00;
      end else if (dump && running[i] && convCnt_r[i] != 8'hff) begin
        convCnt_nxt[i] = convCnt_r[i] + 8'h01;
      end
    end
    irq_nxt = dump && (running != 4'h0);
  end

  // Register conversion state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frameCnt_r <= 11'h0;
      for (int i = 0; i < N; i++) begin
        convCnt_r[i] <= 8'h00;
      end
      irq_r <= 1'b0;
    end else if (ce) begin
      frameCnt_r <= frameCnt_nxt;
      convCnt_r <= convCnt_nxt;
      irq_r <= irq_nxt;
    end
  end
  // Gated so a frozen block does not stretch the pulse
  assign convDoneIrq = irq_r && ce;
  assign chanPowerOn = pon;

  // One filter per channel; even channels measure current
  for (genvar g = 0; g < N; g++) begin : g_chan
    localparam bit CUR = (g % 2) == 0;
    logic [2:0] gainCode;
    if (g < 2) begin : g_lo
      assign gainCode = gainLo_r[(g % 2) * dsadc_pkg::GAIN_HI_POS +: 3];
    end else begin : g_hi
      assign gainCode = gainHi_r[(g % 2) * dsadc_pkg::GAIN_HI_POS +: 3];
    end
    assign pgaGain[3*g +: 3] = clampGain(gainCode, CUR);
    dsadc_dec_filter #(
      .PH_W(4),
      .PHASE_EN(CUR)
    ) u_filt (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .clear(!running[g]),
      .tick(tick),
      .dump(dump),
      .modBits(modSyncB_r[2*g +: 2]),
      .phaseDly(phase_r[(g / 2) * 4 +: 4]),
      .hpfSel(mode_r[dsadc_pkg::F_HPF +: 2]),
      .rateSlow(mode_r[dsadc_pkg::F_RATE]),
      .res16(mode_r[dsadc_pkg::F_RES16]),
      .result(res[g])
    );
  end

  // Checks
  irq_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_r && $past(ce)) |-> $past(dump) && $past(running) != 4'h0)
    else $error("done pulse without frame end");
  irq_single_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (convDoneIrq ##1 ce) |-> !convDoneIrq)
    else $error("done pulse longer than one cycle");
  count_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && !pon[0]) |=> convCnt_r[0] == 8'h00)
    else $error("count not cleared at power-off");
  stop_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!running[1] && $past(!running[1])) |-> $stable(res[1]))
    else $error("stopped channel result changed");
  gain_cur_a: assert property (@(posedge mclk) disable iff (sys_rst)
    pgaGain[8:6] <= dsadc_pkg::GAIN_MAX_CUR)
    else $error("current gain out of range");
  gain_vol_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (gainLo_r[6:4] > 3'h4) |-> pgaGain[5:3] == 3'h4)
    else $error("voltage gain not limited to x16");
  res16_sign_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ($past(irq_nxt) && $past(mode_r[dsadc_pkg::F_RES16]) && $past(running[0]))
      |-> (res[0][23:15] == 9'h000 || res[0][23:15] == 9'h1ff))
    else $error("reduced result not sign extended");
  frame_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frameCnt_r < 11'(dsadc_pkg::DEC_SLOW))
    else $error("frame counter overran slow period");
  rate_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ($past(pon) != 4'h0) |-> $stable(mode_r[dsadc_pkg::F_RATE]))
    else $error("rate changed while powered");
  bresp_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  irq_cov: cover property (@(posedge mclk) disable iff (sys_rst) convDoneIrq);
  wr_cov: cover property (@(posedge mclk) disable iff (sys_rst) wrGo);
  rd_cov: cover property (@(posedge mclk) disable iff (sys_rst) rdGo);
  res16_cov: cover property (@(posedge mclk) disable iff (sys_rst)
    convDoneIrq && mode_r[dsadc_pkg::F_RES16]);
endmodule : dsadc_top
`default_nettype wire

// ---- logic/dsadc_pkg.sv ----
// Constants shared by the delta-sigma converter control block
// Summary of operation
// - Channel runs only with power-on and enable set
// - Filter turns 2-bit modulator codes into 24 bits
// - Each channel result register is 24 bits
// - Two sampling rates selected by configuration
// - High-pass cutoff selectable among four values
// - High-pass removes DC and analogue offset
// - Current channels 0, 2 offer gain x1..x32
// - Voltage channels 1, 3 offer gain x1..x16
// - Mode set by mode and two gain registers
// - Converter clock: crystal or internal oscillator
// - Two current, two voltage differential channels
// - Phase adjustment shifts current channel samples
// - Reduced 16-bit result resolution also supported
package dsadc_pkg;
  localparam int NUM_CH = 4; // Channels
  localparam int RES_W = 24; // Full result width
  localparam int RES16_W = 16; // Reduced result width
  localparam int DEC_FAST = 768; // Modulator ticks per sample, fast rate
  localparam int DEC_SLOW = 1536; // Modulator ticks per sample, slow rate
  localparam int SHIFT_FAST = 11; // Sum scaling, fast rate
  localparam int SHIFT_SLOW = 10; // Sum scaling, slow rate
  localparam int HPF_SHIFT_BASE = 10; // Highest cutoff leak shift
  localparam logic [2:0] GAIN_MAX_CUR = 3'h5; // x32
  localparam logic [2:0] GAIN_MAX_VOL = 3'h4; // x16
  localparam logic [7:0] OFF_MODE = 8'h00; // Mode register
  localparam logic [7:0] OFF_GAIN_LO = 8'h04; // Gain, channels 0 and 1
  localparam logic [7:0] OFF_GAIN_HI = 8'h08; // Gain, channels 2 and 3
  localparam logic [7:0] OFF_PHASE = 8'h0c; // Phase delay, channels 0 and 2
  localparam logic [7:0] OFF_STAT = 8'h10; // Per-channel conversion counts
  localparam logic [7:0] OFF_RES0 = 8'h20; // First result; next ones every 4
  localparam int F_PON = 0; // Power-on bits [3:0]
  localparam int F_CEN = 4; // Conversion enable bits [7:4]
  localparam int F_RATE = 8; // 1 selects slow rate
  localparam int F_RES16 = 9; // 1 selects 16-bit result
  localparam int F_HPF = 10; // Cutoff select [11:10]
  localparam int F_CLK = 12; // 1 selects internal oscillator
  localparam int MODE_W = 13; // Implemented mode bits
  localparam int GAIN_HI_POS = 4; // Second channel field in a gain register
  localparam logic [MODE_W-1:0] MODE_RST = 13'h0000; // All off
  localparam logic [7:0] GAIN_RST = 8'h00; // x1
  localparam logic [7:0] PHASE_RST = 8'h00; // No delay
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI error, unmapped or read-only
endpackage : dsadc_pkg

// ---- logic/dsadc_dec_filter.sv ----
// Decimation and high-pass filter for one converter channel
`timescale 1ns/1ps
`default_nettype none
module dsadc_dec_filter #(
  parameter int PH_W = 4, // Phase delay select width
  parameter bit PHASE_EN = 1'b0 // Delay line present
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic clear, // Channel not running
  input wire logic tick, // Modulator sample strobe
  input wire logic dump, // Frame end, coincides with tick
  input wire logic [1:0] modBits, // Modulator code
  input wire logic [PH_W-1:0] phaseDly, // Delay in modulator ticks
  input wire logic [1:0] hpfSel, // Cutoff select
  input wire logic rateSlow, // Slow rate scaling
  input wire logic res16, // Reduced resolution
  output logic [dsadc_pkg::RES_W-1:0] result // Filtered result
);
  localparam int DLY_N = 2 ** PH_W; // Delay line length
  logic [1:0] dly_r [DLY_N]; // Delay line of modulator codes
  logic [1:0] dly_nxt [DLY_N];
  logic signed [13:0] acc_r, acc_nxt; // Integrator
  logic signed [23:0] dc_r, dc_nxt; // Tracked DC level
  logic [23:0] res_r, res_nxt; // Result register
  logic [1:0] tap; // Selected code
  logic signed [4:0] level; // Code as odd level -3..3
  logic signed [13:0] sum; // Integrator plus current level
  logic signed [24:0] scaled; // Frame sum at 24-bit scale
  logic signed [25:0] err; // Input minus DC
  logic signed [25:0] step; // DC leak step
  logic [23:0] y; // Saturated high-pass output

  // Next state of delay line, integrator and filter
  always_comb begin
    for (int i = 0; i < DLY_N; i++) begin
      dly_nxt[i] = dly_r[i];
    end
    if (tick) begin
      dly_nxt[0] = modBits; // Shift in newest code
      for (int i = 1; i < DLY_N; i++) begin
        dly_nxt[i] = dly_r[i-1];
      end
    end
    tap = PHASE_EN ? dly_r[phaseDly] : modBits;
    level = $signed({2'h0, tap, 1'b0}) - 5'sh3;
    sum = acc_r + 14'(level);
    scaled = rateSlow ? (25'(sum) <<< dsadc_pkg::SHIFT_SLOW)
                      : (25'(sum) <<< dsadc_pkg::SHIFT_FAST);
    err = 26'(scaled) - 26'(dc_r);
    step = err >>> (dsadc_pkg::HPF_SHIFT_BASE + int'(hpfSel));
    if (err > 26'sh07fffff) begin
      y = 24'h7fffff; // Clip high
    end else if (err < -26'sh0800000) begin
      y = 24'h800000; // Clip low
    end else begin
      y = err[23:0];
    end
    acc_nxt = acc_r;
    dc_nxt = dc_r;
    res_nxt = res_r;
    if (clear) begin
      acc_nxt = 14'sh0; // Stopped channel restarts from empty
      dc_nxt = 24'sh0;
    end else if (dump) begin
      acc_nxt = 14'sh0;
      dc_nxt = dc_r + 24'(step);
      // Reduced mode keeps top 16 bits, sign extended
      res_nxt = res16 ? {{8{y[23]}}, y[23:8]} : y;
    end else if (tick) begin
      acc_nxt = sum;
    end
  end

  // Register filter state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < DLY_N; i++) begin
        dly_r[i] <= 2'h0;
      end
      acc_r <= 14'sh0;
      dc_r <= 24'sh0;
      res_r <= 24'h0;
    end else if (ce) begin
      dly_r <= dly_nxt;
      acc_r <= acc_nxt;
      dc_r <= dc_nxt;
      res_r <= res_nxt;
    end
  end

  assign result = res_r;
endmodule : dsadc_dec_filter
`default_nettype wire

// ---- verification/dsadc_mod_model.sv ----
// Far-side model: modulator codes and sample toggles
`timescale 1ns/1ps
`default_nettype none
module dsadc_mod_model (
  input wire logic mclk, // System clock
  input wire logic [1:0] src, // 0 quiet, 1 crystal, 2 oscillator
  input wire logic [7:0] codes, // Codes to present, 2 bits a channel
  output logic [7:0] modIn, // Modulator codes
  output logic tickXtal, // Crystal sample toggle
  output logic tickOsc // Oscillator sample toggle
);
  logic [1:0] ph = 2'h0; // Phase within one sample
  // Quiet start, no toggles
  initial begin
    modIn = 8'h00;
    tickXtal = 1'b0;
    tickOsc = 1'b0;
  end
  // One toggle every 4 clocks; codes move mid-sample so they are settled at each toggle
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    if (ph == 2'h0) begin
      // The unselected source stands still
      tickXtal <= tickXtal ^ (src == 2'h1);
      tickOsc <= tickOsc ^ (src == 2'h2);
    end
    if (ph == 2'h2) modIn <= codes;
  end
endmodule : dsadc_mod_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {string nm; logic [33:0] e; logic [33:0] m;} dsadc_note_type; // Expected answer
  logic mclk, sys_rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid; // Drives
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, modIn, codes; // Addresses, codes
  logic [31:0] s_axi_wdata, s_axi_rdata, r; // Data, random word
  logic [3:0] s_axi_wstrb, chanPowerOn; // Strobes, power-on
  logic [1:0] s_axi_bresp, s_axi_rresp, src; // Responses, tick source
  logic [11:0] pgaGain; // Gain codes
  logic tickXtal, tickOsc, convClkSel, convDoneIrq, prevIrq; // Pins, irq history
  int failures, comparisons, seed, i, irqCnt; // Bookkeeping
  dsadc_note_type q[$]; // Pending answers
  dsadc_note_type note; // Oldest note
  dsadc_top DUT (.mclk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .modIn, .tickXtal, .tickOsc, .chanPowerOn, .pgaGain,
    .convClkSel, .convDoneIrq);
  dsadc_mod_model farSide (.mclk, .src, .codes, .modIn, .tickXtal, .tickOsc);
  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Compare and count
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Verdict and end of run
  task test_done;
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // One bus transfer; ready and the answer are taken at the rising edge they are seen on
  task xfer(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e,
            input logic [33:0] m, input string nm);
    @(posedge mclk);
    q.push_back('{nm, e, m});
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do @(posedge mclk); while ((w ? s_axi_awready : s_axi_arready) !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : xfer
  // Register write, response code expected
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = dsadc_pkg::RESP_OKAY);
    xfer(1'b1, a, d, {rs, 32'h0}, {2'h3, 32'h0}, $sformatf("write %h", a));
  endtask : wr
  // Register read, masked data expected
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
          input logic [1:0] rs = dsadc_pkg::RESP_OKAY);
    xfer(1'b0, a, 32'h0, {rs, e}, {2'h3, m}, $sformatf("read %h", a));
  endtask : rd
  // Bounded wait for the next result set
  task waitIrq;
    int c0;
    int k;
    c0 = irqCnt;
    for (k = 0; k < 4000 && irqCnt == c0; k++) @(posedge mclk);
    if (irqCnt == c0) begin
      failures++;
      test_done;
    end
  endtask : waitIrq
  // Expected gain after clamping
  function automatic logic [2:0] cl(input logic [2:0] c, input logic [2:0] mx);
    return (c > mx) ? mx : c;
  endfunction : cl
  // Monitor: irq pulses and answers against the oldest note
  always @(posedge mclk) begin
    if (convDoneIrq === 1'b1) begin
      irqCnt++;
      chk("irq width", 34'h0, {33'h0, prevIrq});
    end
    prevIrq <= convDoneIrq;
    if ((s_axi_bvalid & s_axi_bready) === 1'b1 || (s_axi_rvalid & s_axi_rready) === 1'b1) begin
      if (q.size() == 0) chk("stray answer", 34'h0, 34'h1);
      else begin
        note = q.pop_front();
        chk(note.nm, note.e, (s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}) & note.m);
      end
    end
  end
  // Watchdog, well above the expected run of about 19000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    test_done;
  end
  // Main sequence
  initial begin
    {failures, comparisons, irqCnt, seed} = {32'h0, 32'h0, 32'h0, 32'd47899};
    {sys_rst, ce, prevIrq, src, codes, s_axi_wstrb} = {3'b110, 2'h0, 8'h00, 4'hf};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    // Reset values, then the refused places
    for (i = 0; i < 6; i++) rd((i < 5) ? 8'(4 * i) : dsadc_pkg::OFF_RES0, 32'h0);
    chk("reset gain", 34'h0, {22'h0, pgaGain});
    rd(8'h14, 32'h0, 32'hffffffff, dsadc_pkg::RESP_SLVERR);
    wr(dsadc_pkg::OFF_STAT, 32'h1, dsadc_pkg::RESP_SLVERR);
    // Every gain code on ch0/ch1, random ones on ch2/ch3
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(dsadc_pkg::OFF_GAIN_LO, {24'h0, 1'b0, i[2:0], 1'b0, i[2:0]});
      wr(dsadc_pkg::OFF_GAIN_HI, {24'h0, 1'b0, r[6:4], 1'b0, r[2:0]});
      chk("gain", {22'h0, cl(r[6:4], dsadc_pkg::GAIN_MAX_VOL), cl(r[2:0], dsadc_pkg::GAIN_MAX_CUR),
        cl(i[2:0], dsadc_pkg::GAIN_MAX_VOL), cl(i[2:0], dsadc_pkg::GAIN_MAX_CUR)}, {22'h0, pgaGain});
    end
    s_axi_wstrb <= 4'h0;
    wr(dsadc_pkg::OFF_GAIN_LO, 32'h0);
    chk("strobe", {28'h0, 6'h25}, {28'h0, pgaGain[5:0]});
    s_axi_wstrb <= 4'hf;
    // Rate bit only moves while powered down
    wr(dsadc_pkg::OFF_MODE, 32'h1);
    wr(dsadc_pkg::OFF_MODE, 32'h101);
    rd(dsadc_pkg::OFF_MODE, 32'h1);
    wr(dsadc_pkg::OFF_MODE, 32'h0);
    wr(dsadc_pkg::OFF_MODE, 32'h100);
    rd(dsadc_pkg::OFF_MODE, 32'h100);
    wr(dsadc_pkg::OFF_MODE, 32'h0);
    // ch0 +3, ch2 -3; ch0/ch2 run, ch1 powered only, ch3 off
    r = $random(seed);
    codes <= {r[7:6], 2'h0, r[3:2], 2'h3};
    wr(dsadc_pkg::OFF_MODE, 32'h57);
    chk("power and clock", 34'he, {29'h0, chanPowerOn, convClkSel});
    src <= 2'h2;
    repeat (6144) @(posedge mclk);
    chk("irq on idle source", 34'h0, 34'(irqCnt));
    src <= 2'h1;
    repeat (6164) @(posedge mclk);
    src <= 2'h0;
    chk("irq count", 34'h2, 34'(irqCnt));
    rd(dsadc_pkg::OFF_RES0, 32'h0, 32'hff800000);
    rd(dsadc_pkg::OFF_RES0 + 8'h4, 32'h0);
    rd(dsadc_pkg::OFF_RES0 + 8'h8, 32'h00800000, 32'hff800000);
    rd(dsadc_pkg::OFF_RES0 + 8'hc, 32'h0);
    rd(dsadc_pkg::OFF_STAT, 32'h00020002, 32'hffff00ff);
    wr(dsadc_pkg::OFF_MODE, 32'h56);
    rd(dsadc_pkg::OFF_STAT, 32'h0, 32'h000000ff);
    // Oscillator clock, lowest cutoff, 16-bit results
    wr(dsadc_pkg::OFF_MODE, 32'h0);
    // Enable held low long enough for a clean restart
    repeat (14) @(posedge mclk);
    wr(dsadc_pkg::OFF_MODE, 32'h1e57);
    rd(dsadc_pkg::OFF_MODE, 32'h1e57);
    chk("osc select", 34'hf, {29'h0, chanPowerOn, convClkSel});
    src <= 2'h2;
    waitIrq();
    waitIrq();
    rd(dsadc_pkg::OFF_RES0 + 8'h8, 32'h00ff8000, 32'hffff8000);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
